/* inc/hdfs_pkg.sv */
package hdfs_pkg;
    localparam int unsigned NUM_PORTS = 7;
    localparam int unsigned ADDR_W    = 8;

    // Register offsets (byte addresses on the plain register port).
    localparam logic [7:0] OFF_RESUME_STATUS  = 8'h4e;
    localparam logic [7:0] OFF_SUSPEND        = 8'h4d;
    localparam logic [7:0] OFF_SE0_STATUS     = 8'h4f;
    localparam logic [7:0] OFF_DIFF_DATA      = 8'h50;
    localparam logic [7:0] OFF_FORCE_LOW_LO   = 8'h51;
    localparam logic [7:0] OFF_FORCE_LOW_HI   = 8'h52;
    localparam logic [7:0] OFF_DRIVE_CODE_LO  = 8'h4b;
    localparam logic [7:0] OFF_DRIVE_CODE_HI  = 8'h4c;

    localparam logic [7:0] RESET_VALUE        = 8'h00;
    localparam logic [7:0] FORCE_LOW_HI_MASK  = 8'h3f;
    localparam logic [7:0] PORT_BITS_MASK     = 8'h7f;
    localparam int unsigned REMOTE_WAKE_BIT   = 7;

    typedef enum logic [1:0] {
        HDFS_DRIVE_NORMAL = 2'h0,
        HDFS_DRIVE_DIFF1  = 2'h1,
        HDFS_DRIVE_DIFF0  = 2'h2,
        HDFS_DRIVE_SE0    = 2'h3
    } hdfs_drive_type;

    // One downstream pin pair: output levels, enables, slew control.
    typedef struct packed {
        logic dp_out;
        logic dm_out;
        logic dp_oe;
        logic dm_oe;
        logic edge_ctrl;
    } hdfs_pin_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wdata;
        logic              wr;
        logic              rd;
    } hdfs_bus_type;
endpackage

/* verilog/hdfs_port_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
// Function
// RL1 - Two-bit drive code forces port lines
// RL2 - Per-pin force-low bit drives pin low
// RL3 - Force-low pins skip edge rate shaping
// RL4 - Force-low holds pins during chip suspend
// RL5 - Firmware may force SE0 while unconfigured
// RL6 - Force-low register bit layout per port
// RL7 - Data readback reports differential state only
// RL8 - Data readback holds value during SE0
// RL9 - SE0 and data readback cleared by resets
// RL10 - SE0 status bits per port, bit7 zero
// RL11 - Data bits show D+ above D-
// RL12 - Firmware marks selectively suspended ports
// RL13 - Repeater blocks traffic to suspended ports
// RL14 - Port resume reflected, flagged, interrupt raised
// RL15 - Disconnect clears selective suspend bit
// RL16 - Bit7 gates resume on connect events
// RL17 - Remote wakeup resume always propagated
// RL18 - Suspend and resume registers reset
// RL19 - Resume bits set by hardware, cleared
// RL20 - Firmware disables port before forcing
// RL21 - Drive code uses speed edge control
// RL22 - Force-low overrides drive code
module hdfs_port_ctrl (
    input  wire logic                                  clk_sys,
    input  wire logic                                  rst_n,
    input  wire logic                                  usb_bus_reset,
    input  wire logic                                  chip_suspend,
    input  wire hdfs_pkg::hdfs_bus_type                bus_in,
    output logic [7:0]                                 bus_rdata,
    input  wire logic [hdfs_pkg::NUM_PORTS-1:0]        line_dp_in,
    input  wire logic [hdfs_pkg::NUM_PORTS-1:0]        line_dm_in,
    input  wire logic [hdfs_pkg::NUM_PORTS-1:0]        port_disconnect,
    input  wire logic [hdfs_pkg::NUM_PORTS-1:0]        port_connect,
    input  wire logic [hdfs_pkg::NUM_PORTS-1:0]        port_remote_wake,
    input  wire logic [hdfs_pkg::NUM_PORTS-1:0]        rep_dp_out,
    input  wire logic [hdfs_pkg::NUM_PORTS-1:0]        rep_dm_out,
    input  wire logic [hdfs_pkg::NUM_PORTS-1:0]        rep_oe,
    input  wire logic [hdfs_pkg::NUM_PORTS-1:0]        rep_resume,
    output hdfs_pkg::hdfs_pin_type [hdfs_pkg::NUM_PORTS-1:0] port_pin,
    output logic                                       hub_irq,
    output logic                                       upstream_resume
);

    localparam int unsigned NP = hdfs_pkg::NUM_PORTS;

    logic          rst_sync1_reg;
    logic          rst_sync2_reg;
    logic          rst_i_n;

    // Reset is applied at once but released through two flops, so no flop
    // leaves reset on an edge that the others miss.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync1_reg <= 1'b0;
            rst_sync2_reg <= 1'b0;
        end else begin
            rst_sync1_reg <= 1'b1;
            rst_sync2_reg <= rst_sync1_reg;
        end
    end
    assign rst_i_n = rst_sync2_reg;

    // Two-stage synchronisers for pin-side inputs.
    logic [NP-1:0] dp_s1_reg;
    logic [NP-1:0] dp_s2_reg;
    logic [NP-1:0] dm_s1_reg;
    logic [NP-1:0] dm_s2_reg;
    logic [NP-1:0] disc_s1_reg;
    logic [NP-1:0] disc_s2_reg;
    logic [NP-1:0] conn_s1_reg;
    logic [NP-1:0] conn_s2_reg;
    logic [NP-1:0] wake_s1_reg;
    logic [NP-1:0] wake_s2_reg;
    logic          bres_s1_reg;
    logic          bres_s2_reg;

    always_ff @(posedge clk_sys or negedge rst_i_n) begin
        if (!rst_i_n) begin
            dp_s1_reg   <= '0;
            dp_s2_reg   <= '0;
            dm_s1_reg   <= '0;
            dm_s2_reg   <= '0;
            disc_s1_reg <= '0;
            disc_s2_reg <= '0;
            conn_s1_reg <= '0;
            conn_s2_reg <= '0;
            wake_s1_reg <= '0;
            wake_s2_reg <= '0;
            bres_s1_reg <= 1'b0;
            bres_s2_reg <= 1'b0;
        end else begin
            dp_s1_reg   <= line_dp_in;
            dp_s2_reg   <= dp_s1_reg;
            dm_s1_reg   <= line_dm_in;
            dm_s2_reg   <= dm_s1_reg;
            disc_s1_reg <= port_disconnect;
            disc_s2_reg <= disc_s1_reg;
            conn_s1_reg <= port_connect;
            conn_s2_reg <= conn_s1_reg;
            wake_s1_reg <= port_remote_wake;
            wake_s2_reg <= wake_s1_reg;
            bres_s1_reg <= usb_bus_reset;
            bres_s2_reg <= bres_s1_reg;
        end
    end

    // Synchronised USB bus reset; it clears status but not the drive controls.
    logic bus_reset;
    assign bus_reset = bres_s2_reg;

    // Register write decode.
    // Writes land at the edge that samples the strobe.
    function automatic logic wr_hit(input hdfs_pkg::hdfs_bus_type b, input logic [7:0] off);
        wr_hit = b.wr && (b.addr == off);
    endfunction

    // Drive code registers: bus reset does not clear them.
    // Firmware clears them itself before the chip enters suspend, and marks
    // a port disabled before forcing it, so the repeater stays out of the way.
    logic [7:0] drive_lo_reg;
    logic [7:0] drive_hi_reg;

    always_ff @(posedge clk_sys or negedge rst_i_n) begin
        if (!rst_i_n) begin
            drive_lo_reg <= hdfs_pkg::RESET_VALUE;
            drive_hi_reg <= hdfs_pkg::RESET_VALUE;
        end else begin
            if (wr_hit(bus_in, hdfs_pkg::OFF_DRIVE_CODE_LO)) begin
                drive_lo_reg <= bus_in.wdata;
            end
            if (wr_hit(bus_in, hdfs_pkg::OFF_DRIVE_CODE_HI)) begin
                drive_hi_reg <= bus_in.wdata & hdfs_pkg::FORCE_LOW_HI_MASK;
            end
        end
    end

    // Force-low registers: D- of port n at bit 2(n-1), D+ above it.
    // The top two bits of the upper register are reserved and read as zero.
    logic [7:0] force_lo_reg;
    logic [7:0] force_hi_reg;

    always_ff @(posedge clk_sys or negedge rst_i_n) begin
        if (!rst_i_n) begin
            force_lo_reg <= hdfs_pkg::RESET_VALUE;
            force_hi_reg <= hdfs_pkg::RESET_VALUE;
        end else begin
            if (wr_hit(bus_in, hdfs_pkg::OFF_FORCE_LOW_LO)) begin
                force_lo_reg <= bus_in.wdata; // RL6
            end
            if (wr_hit(bus_in, hdfs_pkg::OFF_FORCE_LOW_HI)) begin
                force_hi_reg <= bus_in.wdata & hdfs_pkg::FORCE_LOW_HI_MASK; // RL6
            end
        end
    end

    logic [2*NP-1:0] force_bits;
    logic [2*NP-1:0] drive_bits;
    assign force_bits = {force_hi_reg[5:0], force_lo_reg};
    assign drive_bits = {drive_hi_reg[5:0], drive_lo_reg};

    // Line state sensing.
    // Both lines low is SE0; exactly one line high is a differential state.
    logic [NP-1:0] se0_now;
    logic [NP-1:0] diff_valid;
    assign se0_now    = ~dp_s2_reg & ~dm_s2_reg;
    assign diff_valid = dp_s2_reg ^ dm_s2_reg;

    // SE0 status follows the line every cycle; data only follows a
    // differential state, so it keeps the value from before an SE0.
    logic [NP-1:0] se0_reg;
    logic [NP-1:0] diff_reg;

    always_ff @(posedge clk_sys or negedge rst_i_n) begin
        if (!rst_i_n) begin
            se0_reg  <= '0;
            diff_reg <= '0;
        end else if (bus_reset) begin
            se0_reg  <= '0; // RL9
            diff_reg <= '0; // RL9
        end else begin
            se0_reg <= se0_now; // RL10
            for (int i = 0; i < NP; i++) begin
                // Only a differential state updates; SE0 and SE1 hold.
                if (diff_valid[i]) begin
                    diff_reg[i] <= dp_s2_reg[i]; // RL7 RL8 RL11
                end
            end
        end
    end

    // Suspend and resume state.
    logic [NP-1:0] susp_reg;
    // The wakeup enable bit shares the suspend register as its top bit.
    logic          wake_en_reg;
    logic [NP-1:0] resume_reg;
    logic [NP-1:0] port_k;
    logic [NP-1:0] resume_evt;
    // A suspended port showing K, or a remote wakeup, is a resume request.
    assign port_k     = ~dp_s2_reg & dm_s2_reg;
    assign resume_evt = susp_reg & (port_k | wake_s2_reg);

    // Remote wakeup from a suspended port always goes upstream; a connect or
    // disconnect only does so when the wakeup enable bit is set.
    logic          wake_resume;
    logic          change_resume;
    logic [NP-1:0] port_change;
    assign port_change   = conn_s2_reg | disc_s2_reg;
    assign wake_resume   = |(wake_s2_reg & susp_reg); // RL17
    assign change_resume = wake_en_reg & chip_suspend & (|port_change); // RL16

    // A disconnect drops the suspend mark even when firmware writes the
    // register in the same cycle, so a stale mark never outlives the device.

    always_ff @(posedge clk_sys or negedge rst_i_n) begin
        if (!rst_i_n) begin
            susp_reg    <= '0;
            wake_en_reg <= 1'b0;
        end else if (bus_reset) begin
            susp_reg    <= '0; // RL18
            wake_en_reg <= 1'b0; // RL18
        end else begin
            if (wr_hit(bus_in, hdfs_pkg::OFF_SUSPEND)) begin
                susp_reg    <= bus_in.wdata[NP-1:0] & ~disc_s2_reg; // RL15
                wake_en_reg <= bus_in.wdata[hdfs_pkg::REMOTE_WAKE_BIT];
            end else begin
                susp_reg <= susp_reg & ~disc_s2_reg; // RL15
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_i_n) begin
        if (!rst_i_n) begin
            resume_reg <= '0;
        end else if (bus_reset) begin
            // Resume bits follow the suspend mark: clearing the mark clears them.
            resume_reg <= '0; // RL18
        end else begin
            // A new resume event wins over the clear from suspend.
            resume_reg <= (resume_reg & susp_reg) | resume_evt; // RL19
        end
    end

    always_ff @(posedge clk_sys or negedge rst_i_n) begin
        if (!rst_i_n) begin
            hub_irq         <= 1'b0;
            upstream_resume <= 1'b0;
        end else begin
            // The hub interrupt follows every resume event; the wakeup bit never gates it.
            hub_irq         <= |resume_evt; // RL14 RL17
            upstream_resume <= wake_resume | change_resume; // RL16 RL17
        end
    end

    // Pin drive per port.
    // Builds the pin outputs of one port from its controls.
    function automatic hdfs_pkg::hdfs_pin_type pin_drive(
        input logic [1:0] code, input logic fl_dm, input logic fl_dp,
        input logic susp, input logic resume,
        input logic rdp, input logic rdm, input logic roe);
        hdfs_pkg::hdfs_pin_type p;
        p = '0;
        case (hdfs_pkg::hdfs_drive_type'(code)) // RL1
            hdfs_pkg::HDFS_DRIVE_DIFF1: begin
                p.dp_out = 1'b1;
                p.dp_oe  = 1'b1;
                p.dm_oe  = 1'b1;
            end
            hdfs_pkg::HDFS_DRIVE_DIFF0: begin
                p.dm_out = 1'b1;
                p.dp_oe  = 1'b1;
                p.dm_oe  = 1'b1;
            end
            hdfs_pkg::HDFS_DRIVE_SE0: begin
                p.dp_oe = 1'b1;
                p.dm_oe = 1'b1;
            end
            default: begin
                if (susp) begin
                    // Reflect K back to a port that asked for resume.
                    p.dm_out = resume; // RL14 RL13
                    p.dp_oe  = resume;
                    p.dm_oe  = resume;
                end else begin
                    p.dp_out = rdp;
                    p.dm_out = rdm;
                    p.dp_oe  = roe;
                    p.dm_oe  = roe;
                end
            end
        endcase
        // Drive-code forcing keeps the normal USB edge rate; force-low does not.
        p.edge_ctrl = p.dp_oe | p.dm_oe; // RL21
        // Force-low wins over the drive code, suspend and the repeater.
        if (fl_dp) begin
            p.dp_out    = 1'b0; // RL2 RL22
            p.dp_oe     = 1'b1;
            p.edge_ctrl = 1'b0; // RL3
        end
        if (fl_dm) begin
            p.dm_out    = 1'b0; // RL2 RL22
            p.dm_oe     = 1'b1;
            p.edge_ctrl = 1'b0; // RL3
        end
        pin_drive = p;
    endfunction

    // Per-port views of the packed force fields.
    logic [NP-1:0] fl_dm_bits;
    logic [NP-1:0] fl_dp_bits;
    logic [NP-1:0] rep_oe_eff;
    logic [NP-1:0] resume_drive;

    always_comb begin
        for (int i = 0; i < NP; i++) begin
            fl_dm_bits[i] = force_bits[2*i]; // RL6
            fl_dp_bits[i] = force_bits[2*i+1]; // RL6
        end
    end

    // The repeater enable is dropped for a suspended port whose rep_resume is set.
    assign rep_oe_eff   = rep_oe & (~rep_resume | ~susp_reg); // RL13
    assign resume_drive = resume_reg | resume_evt; // RL14

    // Force-low keeps acting regardless of chip_suspend.
    always_ff @(posedge clk_sys or negedge rst_i_n) begin
        if (!rst_i_n) begin
            port_pin <= '0;
        end else begin
            for (int i = 0; i < NP; i++) begin
                port_pin[i] <= pin_drive(drive_bits[2*i +: 2], fl_dm_bits[i], // RL4
                                         fl_dp_bits[i], susp_reg[i],
                                         resume_drive[i],
                                         rep_dp_out[i], rep_dm_out[i],
                                         rep_oe_eff[i]);
            end
        end
    end

    // Read views with the reserved top bits held at zero; the suspend view carries the wakeup enable there.
    logic [7:0] se0_rd;
    logic [7:0] diff_rd;
    logic [7:0] resume_rd;
    logic [7:0] susp_rd;
    assign se0_rd    = {1'b0, se0_reg}; // RL10
    assign diff_rd   = {1'b0, diff_reg}; // RL11
    assign resume_rd = {1'b0, resume_reg}; // RL19
    assign susp_rd   = {wake_en_reg, susp_reg}; // RL16

    // Unmapped offsets and idle cycles read as zero, so the port never
    // shows stale data outside the cycle after a read strobe.
    // Read port: data valid the cycle after the strobe.
    always_ff @(posedge clk_sys or negedge rst_i_n) begin
        if (!rst_i_n) begin
            bus_rdata <= hdfs_pkg::RESET_VALUE;
        end else if (bus_in.rd) begin
            case (bus_in.addr)
                hdfs_pkg::OFF_SE0_STATUS:    bus_rdata <= se0_rd; // RL10
                hdfs_pkg::OFF_DIFF_DATA:     bus_rdata <= diff_rd; // RL11
                hdfs_pkg::OFF_FORCE_LOW_LO:  bus_rdata <= force_lo_reg;
                hdfs_pkg::OFF_FORCE_LOW_HI:  bus_rdata <= force_hi_reg;
                hdfs_pkg::OFF_SUSPEND:       bus_rdata <= susp_rd;
                hdfs_pkg::OFF_RESUME_STATUS: bus_rdata <= resume_rd;
                hdfs_pkg::OFF_DRIVE_CODE_LO: bus_rdata <= drive_lo_reg;
                hdfs_pkg::OFF_DRIVE_CODE_HI: bus_rdata <= drive_hi_reg;
                default:                     bus_rdata <= hdfs_pkg::RESET_VALUE;
            endcase
        end else begin
            bus_rdata <= hdfs_pkg::RESET_VALUE;
        end
    end

endmodule
`default_nettype wire

/* testbench/hdfs_port_ctrl_props.sv */
`timescale 1ns/10ps
`default_nettype none
module hdfs_port_ctrl_props (
    input wire logic                         clk_sys,
    input wire logic                         rst_n,
    input wire logic                         usb_bus_reset,
    input wire hdfs_pkg::hdfs_bus_type       bus_in,
    input wire logic [7:0]                   bus_rdata,
    input wire logic [6:0]                   line_dp_in,
    input wire logic [6:0]                   line_dm_in,
    input wire hdfs_pkg::hdfs_pin_type [6:0] port_pin,
    input wire logic                         hub_irq,
    input wire logic                         upstream_resume
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic rd_sus;
    logic rd_res;
    logic rd_se0;
    logic rd_dat;
    logic rd_hi;
    logic wr_lo;
    logic wr_hi;
    assign rd_sus = bus_in.rd && bus_in.addr == hdfs_pkg::OFF_SUSPEND;
    assign rd_res = bus_in.rd && bus_in.addr == hdfs_pkg::OFF_RESUME_STATUS;
    assign rd_se0 = bus_in.rd && bus_in.addr == hdfs_pkg::OFF_SE0_STATUS;
    assign rd_dat = bus_in.rd && bus_in.addr == hdfs_pkg::OFF_DIFF_DATA;
    assign rd_hi  = bus_in.rd && bus_in.addr == hdfs_pkg::OFF_FORCE_LOW_HI;
    assign wr_lo  = bus_in.wr && bus_in.addr == hdfs_pkg::OFF_FORCE_LOW_LO;
    assign wr_hi  = bus_in.wr && bus_in.addr == hdfs_pkg::OFF_FORCE_LOW_HI;
    chk_se0_reserved: assert property ($past(rd_se0) |-> !bus_rdata[7])
        else $error("SE0 status top bit set");
    chk_data_reserved: assert property ($past(rd_dat) |-> !bus_rdata[7])
        else $error("line data top bit set");
    chk_resume_reserved: assert property ($past(rd_res) |-> !bus_rdata[7])
        else $error("resume status top bit set");
    chk_high_reserved: assert property ($past(rd_hi) |-> bus_rdata[7:6] == 2'h0)
        else $error("upper force-low bits set");
    chk_force_dm_low: assert property (wr_lo && bus_in.wdata[0] |-> ##[1:2]
        (port_pin[0].dm_oe && !port_pin[0].dm_out && !port_pin[0].edge_ctrl))
        else $error("port 1 minus pin not forced low");
    chk_force_p7_dp: assert property (wr_hi && bus_in.wdata[5] |-> ##[1:2]
        (port_pin[6].dp_oe && !port_pin[6].dp_out))
        else $error("port 7 plus pin not forced low");
    chk_diff_one: assert property ((line_dp_in[0] && !line_dm_in[0] &&
        !usb_bus_reset) [*5] ##0 rd_dat |=> bus_rdata[0])
        else $error("line data bit wrong for J");
    chk_se0_one: assert property ((!line_dp_in[0] && !line_dm_in[0] &&
        !usb_bus_reset) [*5] ##0 rd_se0 |=> bus_rdata[0])
        else $error("SE0 status bit missing");
    chk_bus_reset_clear: assert property (usb_bus_reset [*4] ##0
        (rd_dat || rd_sus || rd_res) |=> bus_rdata == 8'h00)
        else $error("register not cleared by bus reset");
    cover property (hub_irq);
    cover property (upstream_resume);
    cover property ($past(rd_res) && bus_rdata[0]);
endmodule
bind hdfs_port_ctrl hdfs_port_ctrl_props i_props (
    .clk_sys, .rst_n, .usb_bus_reset, .bus_in, .bus_rdata, .line_dp_in, .line_dm_in,
    .port_pin, .hub_irq, .upstream_resume
);
`default_nettype wire

/* testbench/hdfs_usb_dev_model.sv */
`timescale 1ns/10ps
`default_nettype none
module hdfs_usb_dev_model (
    input  wire hdfs_pkg::hdfs_pin_type [6:0] port_pin,
    input  wire logic [6:0]                   dev_dp,
    input  wire logic [6:0]                   dev_dm,
    output logic [6:0]                        line_dp,
    output logic [6:0]                        line_dm
);
    // The attached device drives each line only while the hub leaves that pin undriven.
    always_comb begin
        for (int p = 0; p < 7; p++) begin
            line_dp[p] = port_pin[p].dp_oe ? port_pin[p].dp_out : dev_dp[p];
            line_dm[p] = port_pin[p].dm_oe ? port_pin[p].dm_out : dev_dm[p];
        end
    end
endmodule
`default_nettype wire

/* testbench/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic                         clk_sys = 1'b0;
    logic                         rst_n = 1'b0;
    logic                         usb_bus_reset = 1'b0;
    logic                         chip_suspend = 1'b0;
    hdfs_pkg::hdfs_bus_type       bus_in = '0;
    logic [7:0]                   bus_rdata;
    logic [6:0]                   dp, dm, disc = '0, conn = '0, wake = '0;
    logic [6:0]                   rdp = '0, rdm = '0, roe = '0;
    logic [6:0]                   dev_dp = 7'h00, dev_dm = 7'h7f;
    hdfs_pkg::hdfs_pin_type [6:0] port_pin;
    logic                         hub_irq, upstream_resume;
    logic [7:0]                   v;
    logic [1:0]                   s;
    int                           miscompares = 0, comparisons = 0;
    initial forever #25 clk_sys = ~clk_sys;
    hdfs_port_ctrl i_dut (
        .clk_sys, .rst_n, .usb_bus_reset, .chip_suspend, .bus_in, .bus_rdata,
        .line_dp_in(dp), .line_dm_in(dm), .port_disconnect(disc), .port_connect(conn),
        .port_remote_wake(wake), .rep_dp_out(rdp), .rep_dm_out(rdm), .rep_oe(roe),
        .rep_resume(7'h00), .port_pin, .hub_irq, .upstream_resume
    );
    hdfs_usb_dev_model i_dev (.port_pin, .dev_dp, .dev_dm, .line_dp(dp), .line_dm(dm));
    task chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus_in <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_sys);
        bus_in.wr <= 1'b0;
    endtask
    task rc(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        bus_in <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk_sys);
        bus_in.rd <= 1'b0;
        #1 chk($sformatf("reg %h", a), bus_rdata, e);
    endtask
    task settle;
        repeat (4) @(posedge clk_sys);
        #1;
    endtask
    task pin(input int p, input logic [4:0] e, input logic [4:0] m);
        chk($sformatf("pin %0d", p), {3'h0, port_pin[p] & m}, {3'h0, e});
    endtask
    task watch;
        s = 2'h0;
        repeat (8) begin
            @(posedge clk_sys);
            #1 s = s | {hub_irq, upstream_resume};
        end
    endtask
    task print_verdict;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task t_drive;
        logic [19:0] tbl;
        tbl = {5'h06, 5'h0e, 5'h16, 5'h1e};
        {rdp, rdm, roe} <= {3{7'h01}};
        for (int c = 0; c < 4; c++) begin
            wr(hdfs_pkg::OFF_DRIVE_CODE_LO, 8'(c));
            settle;
            pin(0, tbl[5*c +: 5], 5'h1e);
        end
        pin(0, 5'h01, 5'h01);
        wr(hdfs_pkg::OFF_DRIVE_CODE_LO, 8'h00);
    endtask
    task t_force;
        wr(8'h51, 8'h01);
        settle;
        pin(0, 5'h16, 5'h1e);
        wr(8'h51, 8'h02);
        settle;
        pin(0, 5'h0e, 5'h1e);
        wr(hdfs_pkg::OFF_DRIVE_CODE_LO, 8'h01);
        wr(8'h51, 8'hff);
        wr(8'h52, 8'hff);
        chip_suspend <= 1'b1;
        settle;
        pin(0, 5'h06, 5'h1f);
        pin(6, 5'h06, 5'h1f);
        rc(8'h51, 8'hff);
        rc(8'h52, 8'h3f);
        chip_suspend <= 1'b0;
        roe <= 7'h00;
        wr(8'h51, 8'h00);
        wr(8'h52, 8'h00);
        wr(hdfs_pkg::OFF_DRIVE_CODE_LO, 8'h00);
    endtask
    task t_read;
        {dev_dp, dev_dm} <= {7'h7f, 7'h00};
        settle;
        rc(8'h50, 8'h7f);
        rc(8'h4f, 8'h00);
        dev_dp[0] <= 1'b0;
        settle;
        rc(8'h4f, 8'h01);
        rc(8'h50, 8'h7f);
        dev_dm[0] <= 1'b1;
        settle;
        rc(8'h50, 8'h7e);
        wr(8'h4d, 8'h81);
        usb_bus_reset <= 1'b1;
        settle;
        rc(8'h50, 8'h00);
        rc(8'h4d, 8'h00);
        {usb_bus_reset, dev_dp[0], dev_dm[0]} <= 3'h2;
        settle;
    endtask
    task t_susp;
        {rdp, rdm, roe} <= {7'h7f, 7'h00, 7'h7f};
        wr(8'h4d, 8'h01);
        settle;
        pin(0, 5'h00, 5'h06);
        wake[0] <= 1'b1;
        watch;
        chk("irq up", {6'h0, s}, 8'h03);
        pin(0, 5'h0e, 5'h1e);
        wake[0] <= 1'b0;
        rc(8'h4e, 8'h01);
        wr(8'h4d, 8'h00);
        rc(8'h4e, 8'h00);
        wr(8'h4d, 8'h03);
        disc[0] <= 1'b1;
        settle;
        rc(8'h4d, 8'h02);
        disc[0] <= 1'b0;
        wr(8'h4d, 8'h80);
        chip_suspend <= 1'b1;
        conn[1] <= 1'b1;
        watch;
        chk("up wake", {7'h0, s[0]}, 8'h01);
        conn[1] <= 1'b0;
        chip_suspend <= 1'b0;
    endtask
    initial begin
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rc(8'h4d, 8'h00);
        rc(8'h4e, 8'h00);
        rc(8'h51, 8'h00);
        rc(8'h00, 8'h00);
        t_drive;
        t_force;
        t_read;
        t_susp;
        print_verdict;
    end
    initial begin
        repeat (4000) @(posedge clk_sys);
        miscompares++;
        print_verdict;
    end
endmodule
`default_nettype wire
